// ### rtl/bridge_regs.svh
// Purpose: constants of the usb uart bridge wakeup and config block
// Assumes: 10 MHz core clock
// Notes: offsets are config selectors, per channel except custom and thresh
//
// How it works
// - pins reset to inputs with pull-ups
// - activity indicator toggles about every 100ms
// - modem lines active low; dtr push-pull
// - ep0, one config, one interface per channel
// - enter suspend after 3ms bus idle
// - ring pin falling edge wakes host
// - report wakeup; ring wake while pin input
// - enabled ring pins combined by AND
// - enabled rx pins also ANDed for wakeup
// - utf-16le strings, us english, factory serial
// - default vid/pid unless fields programmed
// - cdc flow default 0x0001
// - cdc pin-function default 0x0339
// - cdc pin-direction default 0x0028
// - cdc interrupt mask default 0x03f0
// - cdc threshold 40960, nonvolatile override
// - flag set: cdc requests keep registers
// - bus reset keeps registers and pins
`ifndef BRIDGE_REGS_SVH
`define BRIDGE_REGS_SVH

// ==========================================
// config selectors
`define SEL_FLOW 3'h0
`define SEL_MODE 3'h1
`define SEL_DIR 3'h2
`define SEL_MASK 3'h3
`define SEL_CUSTOM 3'h4
`define SEL_THRESH 3'h5

// ==========================================
// reset and cdc default values
`define FLOW_RESET 16'h0000
`define MODE_RESET 16'h0000
`define DIR_RESET 16'h0000
`define MASK_RESET 16'h0000
`define FLOW_CDC 16'h0001
`define MODE_CDC 16'h0339
`define DIR_CDC 16'h0028
`define MASK_CDC 16'h03f0
`define THRESH_RESET 16'h0000
`define THRESH_CDC 16'ha000

// ==========================================
// field positions: line index and mode bits
`define LN_RING 0
`define LN_CD 1
`define LN_DSR 2
`define LN_DTR 3
`define LN_RTS 5
`define LN_SIX 6
`define LN_SEVEN 7
`define LN_TXIND 8
`define LN_RXIND 9
`define MB_HD_EN 3
`define MB_HD_POL 4
`define MB_TXIND 8
`define MB_RXIND 9
`define FLAG_CUSTOM 0

// ==========================================
// descriptor constants
`define N_CONFIGS 8'h01
`define EP_PER_IF 8'h03
`define N_IFACES 8'h04
`define ATTR_DEFAULT 8'ha0
`define LANG_US 16'h0409
`define STR_MANUF 2'h1
`define STR_PROD 2'h2
`define STR_SERIAL 2'h3

// ==========================================
// timing
`define CLK_KHZ 10000
`define IDLE_TIME_US 3000
`define ACT_TIME_MS 100
`define IDLE_CNT_W 24
`define ACT_CNT_W 24

`endif

// ### rtl/bridge_pkg.sv
// Purpose: types of the usb uart bridge wakeup and config block
// Assumes: four channels of ten lines
// Notes: constants live in bridge_regs.svh
package bridge_pkg;

  typedef enum logic [1:0] {
    LINK_ACTIVE = 2'h0,
    LINK_SUSPEND = 2'h1,
    LINK_WAKE = 2'h3
  } link_state_t;

  typedef logic [3:0][15:0] ch_word_t;
  typedef logic [3:0][9:0] ch_lines_t;

  typedef struct packed {
    link_state_t st;
    logic [23:0] idle_cnt;
    ch_lines_t pin_s1;
    ch_lines_t pin_s2;
    logic [3:0] rx_s1;
    logic [3:0] rx_s2;
    logic ring_and;
    logic rx_and;
    logic custom;
    ch_word_t flow;
    ch_word_t mode;
    ch_word_t dir;
    ch_word_t mask;
    logic [15:0] thresh;
    ch_lines_t pin_out;
    ch_lines_t pin_oe;
    ch_lines_t pull_up;
    logic [3:0][2:0] modem;
    logic [15:0] rdata;
    logic [15:0] vid;
    logic [15:0] pid;
    logic [7:0] str_byte;
    logic wake;
    logic fifo_clear;
  } state_t;

  typedef struct packed {
    logic [23:0] cnt;
    logic ind;
  } act_state_t;

endpackage

// ### rtl/activity_toggle.sv
// Purpose: activity indicator that toggles while its channel moves data
// Assumes: busy comes from logic on the same clock
// Notes: idles high when the channel is quiet
`include "bridge_regs.svh"

module activity_toggle #(
  parameter int unsigned HALF_CYCLES = `ACT_TIME_MS * `CLK_KHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // channel activity
  input wire logic busy,
  // indicator level
  output logic ind_q
);

  bridge_pkg::act_state_t s_q;
  bridge_pkg::act_state_t s_d;

  // ==========================================
  // toggle divider
  always_comb begin
    s_d = s_q;
    if (!busy) begin
      s_d.cnt = '0;
      s_d.ind = 1'b1;
    end else if (s_q.cnt >= 24'(HALF_CYCLES - 1)) begin
      s_d.cnt = '0;
      s_d.ind = ~s_q.ind;
    end else begin
      s_d.cnt = s_q.cnt + 24'h000001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{cnt: 24'h000000, ind: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign ind_q = s_q.ind;

endmodule

// ### rtl/usb_uart_bridge_wakeup_config.sv
// Purpose: suspend, remote wakeup, descriptors and cdc defaults
// Assumes: usb engine and uart logic share clk; pins are asynchronous
// Notes: pin outputs, enables and pull-ups are per line, four channels
`include "bridge_regs.svh"

module usb_uart_bridge_wakeup_config #(
  parameter int unsigned IDLE_CYCLES = `IDLE_TIME_US * `CLK_KHZ / 1000,
  parameter int unsigned ACT_CYCLES = `ACT_TIME_MS * `CLK_KHZ,
  parameter logic [15:0] DEFAULT_VID = 16'h1234, // arbitrary value
  parameter logic [15:0] DEFAULT_PID = 16'h5678 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // usb engine events
  input wire logic bus_activity,
  input wire logic bus_reset,
  input wire logic host_wake_enabled,
  input wire logic cdc_config_req,
  // configuration access
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_ch,
  input wire logic [2:0] cfg_sel,
  input wire logic [15:0] cfg_wdata,
  // nonvolatile settings
  input wire logic [3:0] nv_rx_wake_en,
  input wire logic nv_thresh_valid,
  input wire logic [15:0] nv_thresh,
  input wire logic nv_ids_valid,
  input wire logic [15:0] nv_vid,
  input wire logic [15:0] nv_pid,
  input wire logic [63:0] factory_serial,
  // string lookup
  input wire logic [1:0] str_sel,
  input wire logic [4:0] str_idx,
  // uart side
  input wire logic [3:0] tx_busy,
  input wire logic [3:0] rx_busy,
  input wire logic [3:0] dtr_req,
  input wire logic [3:0] rts_req,
  // pins
  input wire logic [3:0][9:0] line_in,
  input wire logic [3:0] rx_pin,
  output logic [3:0][9:0] line_out,
  output logic [3:0][9:0] line_oe,
  output logic [3:0][9:0] line_pull_up,
  // status
  output logic [3:0][2:0] modem_active,
  output logic suspended,
  output logic remote_wake,
  output logic fifo_clear,
  output logic custom_driver,
  output logic [15:0] cfg_rdata,
  output logic [15:0] vid,
  output logic [15:0] pid,
  output logic [7:0] dev_attr,
  output logic [7:0] num_configs,
  output logic [7:0] num_interfaces,
  output logic [7:0] eps_per_interface,
  output logic [15:0] lang_id,
  output logic [7:0] str_byte
);

  bridge_pkg::state_t s_q;
  bridge_pkg::state_t s_d;
  logic [3:0] tx_ind;
  logic [3:0] rx_ind;

  // ==========================================
  // activity indicators
  for (genvar c = 0; c < 4; c++) begin : g_act
    activity_toggle #(.HALF_CYCLES(ACT_CYCLES)) u_tx (
      .clk(clk),
      .arst_n(arst_n),
      .busy(tx_busy[c]),
      .ind_q(tx_ind[c])
    );
    activity_toggle #(.HALF_CYCLES(ACT_CYCLES)) u_rx (
      .clk(clk),
      .arst_n(arst_n),
      .busy(rx_busy[c]),
      .ind_q(rx_ind[c])
    );
  end

  // ==========================================
  // string rom, utf-16le: odd bytes are zero
  function automatic logic [7:0] str_char(input logic [1:0] sel,
                                          input logic [3:0] i,
                                          input logic [63:0] ser);
    logic [7:0] ch;
    ch = 8'h00;
    unique case (sel)
      `STR_MANUF: begin
        unique case (i)
          4'h0: ch = 8'h56;
          4'h1: ch = 8'h65;
          4'h2: ch = 8'h6e;
          4'h3: ch = 8'h64;
          4'h4: ch = 8'h6f;
          4'h5: ch = 8'h72;
          default: ch = 8'h00;
        endcase
      end
      `STR_PROD: begin
        unique case (i)
          4'h0: ch = 8'h55;
          4'h1: ch = 8'h53;
          4'h2: ch = 8'h42;
          4'h3: ch = 8'h20;
          4'h4: ch = 8'h55;
          4'h5: ch = 8'h41;
          4'h6: ch = 8'h52;
          4'h7: ch = 8'h54;
          default: ch = 8'h00;
        endcase
      end
      `STR_SERIAL: begin
        if (i < 4'h8) begin
          ch = ser[8*i +: 8];
        end
      end
      default: ch = 8'h00;
    endcase
    return ch;
  endfunction

  // ==========================================
  // next state
  always_comb begin
    logic ring_and;
    logic rx_and;
    logic [15:0] rd;
    ring_and = 1'b1;
    rx_and = 1'b1;
    rd = 16'h0000;
    s_d = s_q;
    s_d.fifo_clear = 1'b0;
    s_d.pin_s1 = line_in;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.rx_s1 = rx_pin;
    s_d.rx_s2 = s_q.rx_s1;

    for (int c = 0; c < 4; c++) begin
      // wake only while ring line is still an input
      if (!s_q.dir[c][`LN_RING] && !s_q.pin_s2[c][`LN_RING]) begin
        ring_and = 1'b0;
      end
      if (nv_rx_wake_en[c] && !s_q.rx_s2[c]) begin
        rx_and = 1'b0;
      end
      // active-low modem inputs: ring, cd, dsr
      s_d.modem[c][0] = ~s_q.pin_s2[c][`LN_RING];
      s_d.modem[c][1] = ~s_q.pin_s2[c][`LN_CD];
      s_d.modem[c][2] = ~s_q.pin_s2[c][`LN_DSR];
      for (int l = 0; l < 10; l++) begin
        s_d.pin_oe[c][l] = s_q.dir[c][l];
        s_d.pin_out[c][l] = 1'b1;
      end
      s_d.pin_out[c][`LN_DTR] = ~dtr_req[c];
      s_d.pin_out[c][`LN_RTS] = ~rts_req[c];
      if (s_q.mode[c][`MB_HD_EN]) begin
        s_d.pin_oe[c][`LN_SEVEN] = 1'b1;
        s_d.pin_out[c][`LN_SEVEN] =
          s_q.mode[c][`MB_HD_POL] ? tx_busy[c] : ~tx_busy[c];
      end
      if (s_q.mode[c][`MB_TXIND]) begin
        s_d.pin_oe[c][`LN_TXIND] = 1'b1;
        s_d.pin_out[c][`LN_TXIND] = tx_ind[c];
      end
      if (s_q.mode[c][`MB_RXIND]) begin
        s_d.pin_oe[c][`LN_RXIND] = 1'b1;
        s_d.pin_out[c][`LN_RXIND] = rx_ind[c];
      end
      s_d.pull_up[c] = ~s_d.pin_oe[c];
    end
    s_d.ring_and = ring_and;
    s_d.rx_and = rx_and;

    // link state: idle count, suspend and wake
    unique case (s_q.st)
      bridge_pkg::LINK_ACTIVE: begin
        if (bus_activity) begin
          s_d.idle_cnt = '0;
        end else if (s_q.idle_cnt >= 24'(IDLE_CYCLES - 1)) begin
          s_d.st = bridge_pkg::LINK_SUSPEND;
        end else begin
          s_d.idle_cnt = s_q.idle_cnt + 24'h000001;
        end
      end
      bridge_pkg::LINK_SUSPEND: begin
        if (bus_activity) begin
          s_d.st = bridge_pkg::LINK_ACTIVE;
          s_d.idle_cnt = '0;
        end else if (host_wake_enabled &&
                     ((s_q.ring_and && !ring_and) ||
                      (s_q.rx_and && !rx_and))) begin
          s_d.st = bridge_pkg::LINK_WAKE;
          s_d.wake = 1'b1;
        end
      end
      bridge_pkg::LINK_WAKE: begin
        if (bus_activity) begin
          s_d.st = bridge_pkg::LINK_ACTIVE;
          s_d.idle_cnt = '0;
          s_d.wake = 1'b0;
        end
      end
      default: begin
        s_d.st = bridge_pkg::LINK_ACTIVE;
        s_d.wake = 1'b0;
      end
    endcase

    // configuration writes
    if (cfg_wr) begin
      unique case (cfg_sel)
        `SEL_FLOW: s_d.flow[cfg_ch] = cfg_wdata;
        `SEL_MODE: s_d.mode[cfg_ch] = cfg_wdata;
        `SEL_DIR: s_d.dir[cfg_ch] = cfg_wdata;
        `SEL_MASK: s_d.mask[cfg_ch] = cfg_wdata;
        `SEL_CUSTOM: s_d.custom = cfg_wdata[`FLAG_CUSTOM];
        `SEL_THRESH: s_d.thresh = cfg_wdata;
        default: s_d.custom = s_q.custom;
      endcase
    end

    // cdc defaults only while no custom driver has claimed the device
    if (cdc_config_req && !s_q.custom) begin
      for (int c = 0; c < 4; c++) begin
        s_d.flow[c] = `FLOW_CDC;
        s_d.mode[c] = `MODE_CDC;
        s_d.dir[c] = `DIR_CDC;
        s_d.mask[c] = `MASK_CDC;
      end
      s_d.thresh = nv_thresh_valid ? nv_thresh : `THRESH_CDC;
    end

    // bus reset clears link state and pulses fifo_clear
    if (bus_reset) begin
      s_d.st = bridge_pkg::LINK_ACTIVE;
      s_d.idle_cnt = '0;
      s_d.wake = 1'b0;
      s_d.fifo_clear = 1'b1;
    end

    unique case (cfg_sel)
      `SEL_FLOW: rd = s_q.flow[cfg_ch];
      `SEL_MODE: rd = s_q.mode[cfg_ch];
      `SEL_DIR: rd = s_q.dir[cfg_ch];
      `SEL_MASK: rd = s_q.mask[cfg_ch];
      `SEL_CUSTOM: rd = {15'h0000, s_q.custom};
      `SEL_THRESH: rd = s_q.thresh;
      default: rd = 16'h0000;
    endcase
    s_d.rdata = rd;

    s_d.vid = nv_ids_valid ? nv_vid : DEFAULT_VID;
    s_d.pid = nv_ids_valid ? nv_pid : DEFAULT_PID;
    s_d.str_byte = str_idx[0] ? 8'h00 :
      str_char(str_sel, str_idx[4:1], factory_serial);
  end

  // ==========================================
  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.st <= bridge_pkg::LINK_ACTIVE;
      s_q.pin_s1 <= '1;
      s_q.pin_s2 <= '1;
      s_q.rx_s1 <= '1;
      s_q.rx_s2 <= '1;
      s_q.ring_and <= 1'b1;
      s_q.rx_and <= 1'b1;
      s_q.flow <= {4{`FLOW_RESET}};
      s_q.mode <= {4{`MODE_RESET}};
      s_q.dir <= {4{`DIR_RESET}};
      s_q.mask <= {4{`MASK_RESET}};
      s_q.thresh <= `THRESH_RESET;
      s_q.pin_out <= '1;
      s_q.pull_up <= '1;
      s_q.vid <= DEFAULT_VID;
      s_q.pid <= DEFAULT_PID;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // outputs
  assign line_out = s_q.pin_out;
  assign line_oe = s_q.pin_oe;
  assign line_pull_up = s_q.pull_up;
  assign modem_active = s_q.modem;
  // bit 0 of the state code is set in both low-power states
  assign suspended = s_q.st[0];
  assign remote_wake = s_q.wake;
  assign fifo_clear = s_q.fifo_clear;
  assign custom_driver = s_q.custom;
  assign cfg_rdata = s_q.rdata;
  assign vid = s_q.vid;
  assign pid = s_q.pid;
  assign dev_attr = `ATTR_DEFAULT;
  assign num_configs = `N_CONFIGS;
  assign num_interfaces = `N_IFACES;
  assign eps_per_interface = `EP_PER_IF;
  assign lang_id = `LANG_US;
  assign str_byte = s_q.str_byte;

endmodule

// ### verif/wakeup_config_asserts.sv
// Purpose: property checks of the wakeup and config block
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to every instance of the block
module wakeup_config_asserts #(
  parameter int unsigned IDLE_CYCLES = 30000
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // usb events
  input wire logic bus_activity,
  input wire logic bus_reset,
  input wire logic host_wake_enabled,
  input wire logic cfg_wr,
  input wire logic [3:0] dtr_req,
  // observed outputs
  input wire logic [3:0][9:0] line_out,
  input wire logic [3:0][9:0] line_oe,
  input wire logic [3:0][9:0] line_pull_up,
  input wire logic suspended,
  input wire logic remote_wake,
  input wire logic fifo_clear,
  input wire logic custom_driver,
  input wire logic [7:0] dev_attr,
  input wire logic [7:0] num_configs,
  input wire logic [7:0] num_interfaces,
  input wire logic [7:0] eps_per_interface
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // quiet-bus cycle count
  logic [15:0] idle_q;
  logic [15:0] idle_d;
  logic [3:0] dtr_pin;
  always_comb begin
    idle_d = idle_q + 16'h0001;
    if (bus_activity || bus_reset) begin
      idle_d = 16'h0000;
    end
    for (int i = 0; i < 4; i++) begin
      dtr_pin[i] = line_out[i][3];
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idle_q <= 16'h0000;
    end else begin
      idle_q <= idle_d;
    end
  end
  // ==========
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_quiet;
    !bus_activity && !bus_reset;
  endsequence
  sequence s_clear;
    ##1 fifo_clear ##1 !fifo_clear;
  endsequence
  a_early_suspend: assert property (
    $rose(suspended) |-> idle_q >= IDLE_CYCLES - 1)
    else $error("suspend entered too early");
  a_late_suspend: assert property (
    idle_q >= IDLE_CYCLES + 2 |-> suspended)
    else $error("suspend not entered");
  a_activity_resumes: assert property (
    bus_activity |=> !suspended && !remote_wake)
    else $error("bus activity did not resume");
  a_wake_cause: assert property (
    $rose(remote_wake) |-> $past(suspended) && $past(host_wake_enabled))
    else $error("wakeup without suspend");
  a_wake_holds: assert property (
    remote_wake ##0 s_quiet |=> remote_wake)
    else $error("wakeup dropped early");
  a_fifo_pulse: assert property (bus_reset |-> s_clear)
    else $error("fifo clear pulse missing");
  a_fifo_cause: assert property (fifo_clear |-> $past(bus_reset))
    else $error("fifo clear without bus reset");
  a_reset_keeps: assert property (
    bus_reset && !cfg_wr |=> $stable(custom_driver))
    else $error("bus reset changed driver flag");
  a_pull_inverse: assert property (line_pull_up == ~line_oe)
    else $error("pull-up not inverse of drive");
  a_dtr_follow: assert property (dtr_pin == ~$past(dtr_req))
    else $error("dtr pin not active low");
  a_desc_const: assert property (num_configs == 8'h01 &&
    num_interfaces == 8'h04 && eps_per_interface == 8'h03 && dev_attr[5])
    else $error("descriptor constant wrong");
endmodule

bind usb_uart_bridge_wakeup_config wakeup_config_asserts #(
  .IDLE_CYCLES(IDLE_CYCLES)
) u_chk (.clk, .arst_n, .bus_activity, .bus_reset, .host_wake_enabled,
  .cfg_wr, .dtr_req, .line_out, .line_oe, .line_pull_up, .suspended,
  .remote_wake, .fifo_clear, .custom_driver, .dev_attr, .num_configs,
  .num_interfaces, .eps_per_interface);

// ### verif/usb_host_model.sv
// Purpose: usb host seen from the block: frames, resets, requests
// Assumes: frame markers every eight cycles while the bus runs
// Notes: config accesses stand for control transfers
module usb_host_model (
  // clock
  input wire logic clk,
  // bus events
  output logic bus_activity,
  output logic bus_reset,
  output logic host_wake_enabled,
  output logic cdc_config_req,
  // config access
  output logic cfg_wr,
  output logic [1:0] cfg_ch,
  output logic [2:0] cfg_sel,
  output logic [15:0] cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic frames = 1'b1;
  logic [2:0] fc = 3'h0;
  initial begin
    {bus_reset, host_wake_enabled, cdc_config_req, cfg_wr} = 4'h0;
    {cfg_ch, cfg_sel, cfg_wdata} = 21'h0;
  end
  // frame marker generator
  always begin
    @(posedge clk);
    #1;
    fc = fc + 3'h1;
    bus_activity = frames && (fc == 3'h0);
  end
  task automatic write_reg(input logic [1:0] ch, input logic [2:0] sel,
                           input logic [15:0] d);
    @(posedge clk);
    #1;
    {cfg_wr, cfg_ch, cfg_sel, cfg_wdata} = {1'b1, ch, sel, d};
    @(posedge clk);
    #1 cfg_wr = 1'b0;
  endtask
  task automatic select(input logic [1:0] ch, input logic [2:0] sel);
    @(posedge clk);
    #1 {cfg_ch, cfg_sel} = {ch, sel};
  endtask
  task automatic take_control();
    write_reg(2'h0, 3'h4, 16'h0001);
  endtask
  task automatic cdc_request();
    @(posedge clk);
    #1 cdc_config_req = 1'b1;
    @(posedge clk);
    #1 cdc_config_req = 1'b0;
  endtask
  task automatic usb_reset();
    @(posedge clk);
    #1 bus_reset = 1'b1;
    @(posedge clk);
    #1 bus_reset = 1'b0;
  endtask
  task automatic quiet();
    frames = 1'b0;
    host_wake_enabled = 1'b1;
  endtask
endmodule

// ### verif/tb_usb_uart_bridge_wakeup_config.sv
// Purpose: self-checking bench of the wakeup and config block
// Assumes: idle count 20 and indicator count 4
// Notes: random values from a fixed-seed shift register
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
  n_fail++; $display("wrong value %s exp %h got %h", nm, exp, got); end end
module tb_usb_uart_bridge_wakeup_config;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned IDLE = 20;
  logic clk, arst_n, bus_activity, bus_reset, host_wake_enabled;
  logic cdc_config_req, cfg_wr, nv_thresh_valid, nv_ids_valid;
  logic [1:0] cfg_ch, str_sel;
  logic [2:0] cfg_sel;
  logic [15:0] cfg_wdata, nv_thresh, nv_vid, nv_pid, cfg_rdata, vid, pid;
  logic [63:0] factory_serial;
  logic [4:0] str_idx;
  logic [3:0] nv_rx_wake_en, tx_busy, rx_busy, dtr_req, rts_req, rx_pin;
  logic [3:0][9:0] line_in, line_out, line_oe, line_pull_up;
  logic [3:0][2:0] modem_active;
  logic suspended, remote_wake, fifo_clear, custom_driver;
  logic [7:0] dev_attr, num_configs, num_interfaces, eps_per_interface;
  logic [7:0] str_byte;
  logic [15:0] lang_id;
  logic [31:0] rnd = 32'h312f0073;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  usb_uart_bridge_wakeup_config #(.IDLE_CYCLES(IDLE), .ACT_CYCLES(4),
    .DEFAULT_VID(16'h2a2a), .DEFAULT_PID(16'h5b5b) // arbitrary values
  ) dut (.clk, .arst_n, .bus_activity, .bus_reset, .host_wake_enabled,
    .cdc_config_req, .cfg_wr, .cfg_ch, .cfg_sel, .cfg_wdata,
    .nv_rx_wake_en, .nv_thresh_valid, .nv_thresh, .nv_ids_valid, .nv_vid,
    .nv_pid, .factory_serial, .str_sel, .str_idx, .tx_busy, .rx_busy,
    .dtr_req, .rts_req, .line_in, .rx_pin, .line_out, .line_oe,
    .line_pull_up, .modem_active, .suspended, .remote_wake, .fifo_clear,
    .custom_driver, .cfg_rdata, .vid, .pid, .dev_attr, .num_configs,
    .num_interfaces, .eps_per_interface, .lang_id, .str_byte);
  usb_host_model u_host (.clk, .bus_activity, .bus_reset,
    .host_wake_enabled, .cdc_config_req, .cfg_wr, .cfg_ch, .cfg_sel,
    .cfg_wdata);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] cdc_def(input logic [2:0] sel);
    return sel == 3'h0 ? 16'h0001 : sel == 3'h1 ? 16'h0339 :
           sel == 3'h2 ? 16'h0028 : 16'h03f0;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [1:0] ch, input logic [2:0] sel,
                    output logic [15:0] v);
    u_host.select(ch, sel);
    step(2);
    v = cfg_rdata;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // ==========
  // scenarios
  initial begin
    int tgl;
    logic prev;
    logic [1:0] ch;
    logic [15:0] w, wr;
    arst_n = 1'b0;
    {nv_thresh_valid, nv_ids_valid, str_sel, str_idx} = 9'h0;
    {nv_thresh, nv_vid, nv_pid} = 48'h0;
    {nv_rx_wake_en, tx_busy, rx_busy, dtr_req, rts_req} = 20'h0;
    line_in = '1;
    rx_pin = 4'hf;
    factory_serial = {rnd, lfsr(rnd)};
    repeat (3) @(posedge clk);
    #1 arst_n = 1'b1;
    step(1);
    `CHK("line_oe", 40'h0, line_oe)
    `CHK("pull_up", {40{1'b1}}, line_pull_up)
    `CHK("vid", 16'h2a2a, vid)
    `CHK("lang", 16'h0409, lang_id)
    $display("end of reset test");
    str_sel = 2'h3;
    for (int k = 0; k < 16; k++) begin
      str_idx = k[4:0];
      step(1);
      `CHK("serial", k[0] ? 8'h00 : factory_serial[8*(k/2) +: 8],
           str_byte)
    end
    str_sel = 2'h1;
    str_idx = 5'h00;
    step(1);
    `CHK("manuf", 8'h56, str_byte)
    str_sel = 2'h2;
    step(1);
    `CHK("product", 8'h55, str_byte)
    rnd = lfsr(lfsr(rnd));
    {nv_vid, nv_pid, nv_ids_valid} = {rnd, 1'b1};
    step(2);
    `CHK("vid", nv_vid, vid)
    `CHK("pid", nv_pid, pid)
    $display("end of descriptor test");
    ch = rnd[1:0];
    u_host.cdc_request();
    for (int s = 0; s < 4; s++) begin
      rd(ch, s[2:0], w);
      `CHK("cdc reg", cdc_def(s[2:0]), w)
    end
    rd(ch, 3'h5, w);
    `CHK("thresh", 16'ha000, w)
    `CHK("oe", 3'b101, line_oe[ch][5:3])
    {nv_thresh_valid, nv_thresh} = {1'b1, rnd[31:16]};
    u_host.cdc_request();
    rd(ch, 3'h5, w);
    `CHK("thresh", nv_thresh, w)
    $display("end of cdc default test");
    dtr_req = rnd[3:0];
    line_in[ch][2] = 1'b0;
    step(4);
    `CHK("dtr", ~dtr_req, {line_out[3][3], line_out[2][3], line_out[1][3],
                         line_out[0][3]})
    `CHK("dsr", 1'b1, modem_active[ch][2])
    line_in[ch][2] = 1'b1;
    tx_busy[ch] = 1'b1;
    tgl = 0;
    for (int k = 0; k < 40; k++) begin
      prev = line_out[ch][8];
      step(1);
      tgl += (prev !== line_out[ch][8]);
    end
    `CHK("toggles", 1'b1, tgl >= 9 && tgl <= 11)
    `CHK("hd drive", 1'b1, line_out[ch][7])
    tx_busy[ch] = 1'b0;
    step(3);
    `CHK("idle ind", 1'b1, line_out[ch][8])
    `CHK("hd idle", 1'b0, line_out[ch][7])
    $display("end of pin test");
    `CHK("awake", 1'b0, suspended)
    line_in[2][0] = 1'b0;
    u_host.quiet();
    step(IDLE + 4);
    `CHK("suspended", 1'b1, suspended)
    line_in[0][0] = 1'b0;
    step(8);
    `CHK("blocked", 1'b0, remote_wake)
    {line_in[0][0], line_in[2][0]} = 2'b11;
    step(8);
    line_in[0][0] = 1'b0;
    step(8);
    `CHK("ring wake", 1'b1, remote_wake)
    u_host.frames = 1'b1;
    step(10);
    `CHK("resumed", 2'b00, {remote_wake, suspended})
    line_in[0][0] = 1'b1;
    nv_rx_wake_en = 4'h6;
    u_host.quiet();
    step(IDLE + 12);
    rx_pin[0] = 1'b0;
    step(8);
    `CHK("rx off", 1'b0, remote_wake)
    rx_pin[1] = 1'b0;
    step(8);
    `CHK("rx wake", 1'b1, remote_wake)
    u_host.frames = 1'b1;
    rx_pin = 4'hf;
    step(10);
    $display("end of wakeup test");
    u_host.take_control();
    step(1);
    `CHK("custom", 1'b1, custom_driver)
    wr = rnd[15:0];
    u_host.write_reg(ch, 3'h2, wr);
    u_host.cdc_request();
    rd(ch, 3'h2, w);
    `CHK("dir kept", wr, w)
    u_host.usb_reset();
    rd(ch, 3'h2, w);
    `CHK("dir reset", wr, w)
    `CHK("custom", 1'b1, custom_driver)
    u_host.write_reg(2'h0, 3'h4, 16'h0000);
    u_host.cdc_request();
    rd(ch, 3'h2, w);
    `CHK("dir cdc", 16'h0028, w)
    $display("end of driver test");
    tally_and_finish();
  end
endmodule
